// ===== hdl/wdt_consts.svh
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define WDT_ADDR_CTRL 8'ha5
`define WDT_ADDR_COUNT 8'hff

// ----------------------------------------------------------------
// Control values and reset values
// ----------------------------------------------------------------
`define WDT_CTRL_RESET 8'ha5
`define WDT_CTRL_HALT 8'ha5
`define WDT_CTRL_UNLOCK 8'h5a
`define WDT_CTRL_LOCKED 8'h00
`define WDT_COUNT_RESET 8'h00
`define WDT_COUNT_MAX 8'hff
`define WDT_READ_NONE 8'h00

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define WDT_PRESC_W 11
`define WDT_COUNT_W 8
`define WDT_DIV_CW 16
`define WDT_PULSE_CW 16
`define WDT_PRESC_MAX 11'h7ff

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WDT_SYS_FREQ_KHZ 100000
`define WDT_OSC_FREQ_KHZ 1000
`define WDT_OSC_DIV (`WDT_SYS_FREQ_KHZ / `WDT_OSC_FREQ_KHZ)
`define WDT_PRESC_PERIOD 2048
`define WDT_PULSE_MULT 16
`define WDT_PULSE_TICKS (`WDT_PULSE_MULT * `WDT_PRESC_PERIOD)

`endif

// ===== hdl/wdt_pkg.sv
`include "wdt_consts.svh"

package wdt_pkg;

	typedef enum logic [1:0] {
		WDT_PS_IDLE = 2'b01,
		WDT_PS_ACTIVE = 2'b10
	} wdt_pulse_state_t;

	typedef struct packed {
		logic [`WDT_DIV_CW-1:0] div;
		logic tick;
	} wdt_osc_state_t;

	typedef struct packed {
		wdt_pulse_state_t state;
		logic [`WDT_PULSE_CW-1:0] cnt;
		logic busy;
	} wdt_pulse_t;

	typedef struct packed {
		logic [`WDT_COUNT_W-1:0] ctrl;
		logic [`WDT_COUNT_W-1:0] count;
		logic [`WDT_PRESC_W-1:0] presc;
		logic pin_meta;
		logic pin_sync;
		logic [`WDT_COUNT_W-1:0] rd_data;
		logic chip_rst;
		logic pin_drive;
		logic running;
	} wdt_core_t;

endpackage

// ===== hdl/wdt_link_if.sv
`timescale 1ns/1ps

interface wdt_link_if;
	logic run;
	logic tick;
	logic fire;
	logic busy;

	modport osc(input run, output tick);
	modport pulse(input fire, input tick, output busy);
	modport core(output run, output fire, input tick, input busy);
endinterface

// ===== hdl/wdt_osc_tick.sv
`timescale 1ns/1ps
`include "wdt_consts.svh"

// Stands in for the dedicated watchdog oscillator: one tick per oscillator cycle
module wdt_osc_tick #(
	parameter int OSC_DIV = `WDT_OSC_DIV
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	wdt_link_if.osc lnk
);
	localparam logic [`WDT_DIV_CW-1:0] DIV_LAST = `WDT_DIV_CW'(OSC_DIV - 1);

	wdt_pkg::wdt_osc_state_t state_reg;
	wdt_pkg::wdt_osc_state_t state_next;

	always_comb begin
		state_next = state_reg;
		state_next.tick = 1'b0;
		if (!lnk.run) begin
			// Oscillator stopped: phase restarts on the next enable
			state_next.div = '0; // [R09]
		end else if (state_reg.div == DIV_LAST) begin
			state_next.div = '0;
			state_next.tick = 1'b1; // [R02]
		end else begin
			state_next.div = state_reg.div + `WDT_DIV_CW'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_reg <= '0;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	assign lnk.tick = state_reg.tick;
endmodule

// ===== hdl/wdt_rst_pulse.sv
`timescale 1ns/1ps
`include "wdt_consts.svh"

// Stretches an overflow into the long reset pulse, timed in oscillator ticks
module wdt_rst_pulse #(
	parameter int PULSE_TICKS = `WDT_PULSE_TICKS
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	wdt_link_if.pulse lnk
);
	localparam logic [`WDT_PULSE_CW-1:0] CNT_LAST = `WDT_PULSE_CW'(PULSE_TICKS - 1);

	wdt_pkg::wdt_pulse_t state_reg;
	wdt_pkg::wdt_pulse_t state_next;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg.state)
			wdt_pkg::WDT_PS_IDLE: begin
				if (lnk.fire) begin
					state_next.state = wdt_pkg::WDT_PS_ACTIVE;
					state_next.cnt = '0;
					state_next.busy = 1'b1;
				end
			end
			wdt_pkg::WDT_PS_ACTIVE: begin
				if (lnk.tick) begin
					if (state_reg.cnt == CNT_LAST) begin
						state_next.state = wdt_pkg::WDT_PS_IDLE;
						state_next.busy = 1'b0; // [R05]
					end else begin
						state_next.cnt = state_reg.cnt + `WDT_PULSE_CW'(1);
					end
				end
			end
			default: begin
				state_next.state = wdt_pkg::WDT_PS_IDLE;
				state_next.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_reg <= '{state: wdt_pkg::WDT_PS_IDLE, cnt: '0, busy: 1'b0};
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	assign lnk.busy = state_reg.busy;
endmodule

// ===== hdl/wdt_top.sv
`timescale 1ns/1ps
`include "wdt_consts.svh"

//
// Overview of operation
// R01: Watchdog is an 11-bit prescaler feeding an 8-bit software-visible count.
// R02: Prescaler advances on every cycle of the dedicated 1 MHz oscillator.
// R03: Count increments once every 2048 oscillator cycles.
// R04: Count overflow resets the whole microcontroller.
// R05: Overflow drives a reset pulse on the reset pin for 16 x 2048 oscillator cycles.
// R06: Internal watchdog reset applies even while the reset pin is held low.
// R07: During reset ports 1-3 are forced high and port 0 floats.
// R08: Control register sits at address a5 and is readable and writable.
// R09: Control value a5 stops the oscillator and holds prescaler and count cleared; the code keeps the oscillator running while the reset pulse is timed.
// R10: Any reset loads the control register with a5, disabling the watchdog.
// R11: Any control value other than a5 enables the watchdog.
// R12: Enabled watchdog counts independently of the crystal clock.
// R13: Reading the count returns the live value without stopping it.
// R14: A count write is accepted only while control holds 5a.
// R15: Accepted count write clears prescaler and control, keeping watchdog enabled and locked.
// R16: Software must reload the count before the timeout expires.
// R17: Timeout from reload is (256 - loaded count) x 2048 oscillator periods.
// R18: Watchdog reset ends power-down like an external reset; only RAM survives.
// R19: Overflow means the count wrapping from ff to 00 on an increment.
// R20: A count write while control is not 5a is ignored entirely.
module wdt_top #(
	parameter int OSC_DIV = `WDT_OSC_DIV,
	parameter int PULSE_TICKS = `WDT_PULSE_TICKS
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	input wire logic rst_pin_i,
	output logic rst_pin_o,
	output logic rst_pin_oe,
	output logic chip_reset,
	output logic port_force_high,
	output logic port0_hiz,
	output logic wdt_running
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
		return a == target;
	endfunction

	function automatic logic [7:0] read_mux(input logic [7:0] a, input wdt_pkg::wdt_core_t s);
		logic [7:0] v;
		v = `WDT_READ_NONE;
		if (hit(a, `WDT_ADDR_CTRL)) begin
			v = s.ctrl; // [R08]
		end else if (hit(a, `WDT_ADDR_COUNT)) begin
			v = s.count; // [R13]
		end
		return v;
	endfunction

	// Reset value: control holds the halt code, the chip sees reset, pins park
	localparam wdt_pkg::wdt_core_t CORE_RESET = '{
		ctrl: `WDT_CTRL_RESET,
		count: `WDT_COUNT_RESET,
		presc: '0,
		pin_meta: 1'b0,
		pin_sync: 1'b0,
		rd_data: `WDT_READ_NONE,
		chip_rst: 1'b1,
		pin_drive: 1'b0,
		running: 1'b0
	};

	// ----------------------------------------------------------------
	// Oscillator tick and reset pulse stretcher
	// ----------------------------------------------------------------
	wdt_link_if lnk();

	wdt_osc_tick #(
		.OSC_DIV(OSC_DIV)
	) u_osc (
		.sys_clk(sys_clk),
		.rst(rst),
		.ce(ce),
		.lnk(lnk.osc)
	);

	wdt_rst_pulse #(
		.PULSE_TICKS(PULSE_TICKS)
	) u_pulse (
		.sys_clk(sys_clk),
		.rst(rst),
		.ce(ce),
		.lnk(lnk.pulse)
	);

	// ----------------------------------------------------------------
	// Core state
	// ----------------------------------------------------------------
	wdt_pkg::wdt_core_t state_reg;
	wdt_pkg::wdt_core_t state_next;
	logic halted;
	logic any_rst;
	logic presc_wrap;
	logic overflow;
	logic count_wr_ok;

	always_comb begin
		halted = state_reg.ctrl == `WDT_CTRL_HALT; // [R09] [R11]
		// Pin level is only trusted after the second flop
		any_rst = lnk.busy | state_reg.pin_sync; // [R04] [R10]
		presc_wrap = state_reg.presc == `WDT_PRESC_MAX;
		overflow = !halted && lnk.tick && presc_wrap && state_reg.count == `WDT_COUNT_MAX; // [R19]
		count_wr_ok = wr_en && hit(addr, `WDT_ADDR_COUNT) && state_reg.ctrl == `WDT_CTRL_UNLOCK; // [R14] [R20]

		state_next = state_reg;
		state_next.pin_meta = rst_pin_i;
		state_next.pin_sync = state_reg.pin_meta;

		// Read data stands for exactly one cycle after the strobe
		state_next.rd_data = `WDT_READ_NONE;
		if (rd_en) begin
			state_next.rd_data = read_mux(addr, state_reg); // [R13]
		end

		if (any_rst) begin
			state_next.ctrl = `WDT_CTRL_RESET; // [R10]
			state_next.count = `WDT_COUNT_RESET;
			state_next.presc = '0;
		end else begin
			if (halted) begin
				state_next.presc = '0; // [R09]
				state_next.count = `WDT_COUNT_RESET;
			end else if (lnk.tick) begin
				state_next.presc = state_reg.presc + `WDT_PRESC_W'(1); // [R01] [R02] [R12]
				if (presc_wrap) begin
					// Wraps to zero on overflow; the reset then clears it anyway
					state_next.count = state_reg.count + `WDT_COUNT_W'(1); // [R03] [R17]
				end
			end
			// An accepted count write overrides a coincident tick; a control write leaves it in effect
			if (wr_en && hit(addr, `WDT_ADDR_CTRL)) begin
				state_next.ctrl = wr_data; // [R08]
			end else if (count_wr_ok) begin
				state_next.count = wr_data; // [R14] [R17]
				state_next.presc = '0; // [R15]
				state_next.ctrl = `WDT_CTRL_LOCKED; // [R15]
			end
		end

		// Pin input is not gating this: the watchdog pulse asserts chip reset by itself
		state_next.chip_rst = any_rst; // [R06] [R18]
		state_next.pin_drive = lnk.busy; // [R05]
		state_next.running = !halted && !any_rst; // [R11]
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_reg <= CORE_RESET;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// Link to the helper modules
	// ----------------------------------------------------------------
	// Oscillator keeps running while the pulse is timed, even though control is at halt
	assign lnk.run = !halted || lnk.busy; // [R09] [R05]
	assign lnk.fire = overflow; // [R04]

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign rd_data = state_reg.rd_data;
	assign rst_pin_o = state_reg.pin_drive; // [R05]
	assign rst_pin_oe = state_reg.pin_drive;
	assign chip_reset = state_reg.chip_rst; // [R04]
	assign port_force_high = state_reg.chip_rst; // [R07]
	assign port0_hiz = state_reg.chip_rst; // [R07]
	assign wdt_running = state_reg.running;
endmodule

// ===== test/wdt_top_assertions.sv
`timescale 1ns/1ps
`include "wdt_consts.svh"

module wdt_top_assertions #(
	parameter int OSC_DIV = `WDT_OSC_DIV,
	parameter int PULSE_TICKS = `WDT_PULSE_TICKS
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic rd_en,
	input wire logic [7:0] rd_data,
	input wire logic rst_pin_i,
	input wire logic rst_pin_o,
	input wire logic rst_pin_oe,
	input wire logic chip_reset,
	input wire logic port_force_high,
	input wire logic port0_hiz,
	input wire logic wdt_running
);
	// ----------------------------------------
	// Pulse length in system cycles
	// ----------------------------------------
	// Wide enough for the full-length pulse at the default divider
	localparam int PT = PULSE_TICKS * OSC_DIV;
	logic [31:0] hi_cnt;

	always_ff @(posedge sys_clk) begin
		if (rst || !rst_pin_o) begin
			hi_cnt <= 32'h00000000;
		end else begin
			hi_cnt <= hi_cnt + 32'h00000001;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	AST_RD_IDLE: assert property (!$past(rd_en) |-> rd_data == 8'h00)
		else $error("read data outside read slot");
	AST_UNMAPPED: assert property (rd_en && addr != 8'ha5 && addr != 8'hff |=> rd_data == 8'h00)
		else $error("unmapped read not zero");
	AST_PORTS: assert property (port_force_high == chip_reset && port0_hiz == chip_reset)
		else $error("ports not following reset");
	AST_DRIVE: assert property (rst_pin_oe |-> rst_pin_o && chip_reset)
		else $error("pin drive without internal reset");
	AST_PIN_IN: assert property (rst_pin_i [*4] |-> chip_reset)
		else $error("reset pin ignored");
	AST_RUN_OFF: assert property (chip_reset [*2] |-> !wdt_running)
		else $error("running during reset");
	AST_PULSE_LEN: assert property ($fell(rst_pin_o) |-> hi_cnt >= PT - OSC_DIV && hi_cnt <= PT + OSC_DIV)
		else $error("reset pulse length wrong");
	AST_NO_RETRIG: assert property ($fell(rst_pin_o) |-> !rst_pin_o [*8])
		else $error("pulse retriggered");
endmodule

bind wdt_top wdt_top_assertions #(.OSC_DIV(OSC_DIV), .PULSE_TICKS(PULSE_TICKS)) wdt_top_assertions_inst (
	.sys_clk, .rst, .addr, .rd_en, .rd_data, .rst_pin_i, .rst_pin_o, .rst_pin_oe,
	.chip_reset, .port_force_high, .port0_hiz, .wdt_running);

// ===== test/tb_top.sv
`timescale 1ns/1ps

module tb_top;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic rst_pin_i = 1'b0;
	logic [7:0] rd_data;
	logic [7:0] v;
	logic rst_pin_o, rst_pin_oe, chip_reset, port_force_high, port0_hiz, wdt_running;
	int errors = 0;
	int n_checks = 0;
	int cyc = 0;

	always #5 sys_clk = ~sys_clk;

	// Short oscillator divider and pulse keep the run small
	wdt_top #(.OSC_DIV(2), .PULSE_TICKS(8)) wdt_top_inst (.sys_clk, .rst, .ce, .addr, .wr_data, .wr_en,
		.rd_en, .rd_data, .rst_pin_i, .rst_pin_o, .rst_pin_oe, .chip_reset, .port_force_high,
		.port0_hiz, .wdt_running);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task tally_and_finish;
		if (errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task wait_n(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask

	task rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1 v = rd_data;
		chk(nm, v, exp);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_defaults;
		rchk("ctrl", 8'ha5, 8'ha5);
		rchk("count", 8'hff, 8'h00);
		rchk("unmapped", 8'h10, 8'h00);
		chk("running", {7'h00, wdt_running}, 8'h00);
	endtask

	task t_enable;
		wr(8'hff, 8'h33);
		rchk("count", 8'hff, 8'h00);
		wr(8'ha5, 8'h12);
		wait_n(2);
		chk("running", {7'h00, wdt_running}, 8'h01);
		rchk("ctrl", 8'ha5, 8'h12);
		wr(8'hff, 8'h44);
		rchk("count", 8'hff, 8'h00);
		wr(8'ha5, 8'ha5);
		wait_n(2);
		chk("running", {7'h00, wdt_running}, 8'h00);
	endtask

	// Oscillator phase is free-running, so waits leave a margin of many ticks
	task t_reload;
		wr(8'ha5, 8'h5a);
		wr(8'hff, 8'hf0);
		rchk("count", 8'hff, 8'hf0);
		rchk("ctrl", 8'ha5, 8'h00);
		wr(8'hff, 8'h10);
		rchk("count", 8'hff, 8'hf0);
		wait_n(8292);
		rchk("count", 8'hff, 8'hf2);
		wait_n(4096);
		rchk("count", 8'hff, 8'hf3);
		wr(8'ha5, 8'ha5);
		wait_n(2);
		rchk("count", 8'hff, 8'h00);
	endtask

	// Enabled first, so the control read-back really shows the reload to a5
	task t_pin;
		wr(8'ha5, 8'h5a);
		@(posedge sys_clk);
		rst_pin_i <= 1'b1;
		wait_n(6);
		chk("chip_reset", {7'h00, chip_reset}, 8'h01);
		chk("running", {7'h00, wdt_running}, 8'h00);
		wr(8'ha5, 8'h5a);
		@(posedge sys_clk);
		rst_pin_i <= 1'b0;
		wait_n(6);
		rchk("ctrl", 8'ha5, 8'ha5);
	endtask

	task t_overflow;
		int n;
		wr(8'ha5, 8'h5a);
		// Prescaler runs well up first: a reload that left it standing overflows early
		wait_n(2000);
		wr(8'hff, 8'hfe);
		n = 0;
		while (chip_reset !== 1'b1 && n < 9000) begin
			wait_n(1);
			n++;
		end
		chk("timeout", {7'h00, n >= 8186 && n <= 8196}, 8'h01);
		chk("pin", {6'h00, rst_pin_o, rst_pin_oe}, 8'h03);
		chk("ports", {6'h00, port_force_high, port0_hiz}, 8'h03);
		n = 0;
		while (chip_reset !== 1'b0 && n < 100) begin
			wait_n(1);
			n++;
		end
		chk("pulse", {7'h00, n >= 14 && n <= 17}, 8'h01);
		rchk("ctrl", 8'ha5, 8'ha5);
		rchk("count", 8'hff, 8'h00);
	endtask

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			errors++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		wait_n(5);
		t_defaults();
		t_enable();
		t_reload();
		t_pin();
		t_overflow();
		tally_and_finish();
	end
endmodule
